// [rtl/cmh_regs.svh]
`ifndef CMH_REGS_SVH
`define CMH_REGS_SVH
// Register word offsets (byte addresses); CMH_OBJ_BASE is the value of address bits 7:6
`define CMH_NODE_CTRL   8'h00
`define CMH_NODE_STAT   8'h04
`define CMH_FC_CTRL     8'h08
`define CMH_FC_VALUE    8'h0c
`define CMH_SUSP_CFG    8'h10
`define CMH_RXQ_DATA    8'h14
`define CMH_RXQ_STAT    8'h18
`define CMH_OBJ_BASE    2'h1
// Node control / status bits
`define CMH_INIT_BIT    0
`define CMH_LOE_BIT     0
// Object control bits
`define CMH_O_VALID     0
`define CMH_O_RECEIVE_ALLOW      1
`define CMH_O_TXA       2
`define CMH_O_TXB       3
`define CMH_O_TRANSMIT_REQUEST      4
`define CMH_O_NEW_DATA_FLAG    5
`define CMH_O_LOST      6
`define CMH_O_RECEIVE_PENDING_FLAG     7
`define CMH_O_SDT       8
`define CMH_O_FOREIGN_REMOTE_ENABLE     9
`define CMH_O_DIR       10
`define CMH_O_ID_LO     16
`define CMH_O_ID_HI     26
// Frame counter control fields
`define CMH_FC_SUB_LO   0
`define CMH_FC_SUB_HI   2
`define CMH_FC_FUN_LO   4
`define CMH_FC_FUN_HI   5
`define CMH_FUN_BITTIME 2'h2
`define CMH_SUB_RXREC   3'h1
`define CMH_SUB_TXDOM   3'h2
`define CMH_SUB_TXREC   3'h3
`define CMH_SUB_SYNC    3'h4
// Reset values and bus answers
`define CMH_NODE_RST    32'h0000_0001
`define CMH_RESP_OKAY   2'h0
`define CMH_RESP_SLVERR 2'h2
`endif

// [rtl/cmh_pkg.sv]
package cmh_pkg;
    typedef enum logic [0:0] {CMH_TX_IDLE, CMH_TX_ACTIVE} cmh_tx_e;
    typedef logic [10:0] cmh_id_t;
    typedef logic [1:0]  cmh_resp_t;
endpackage

// [rtl/cmh_fifo.sv]
`timescale 1ns/100ps
module cmh_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } cmh_fifo_s;
    cmh_fifo_s r_ff, nxt_r;
    logic push, pop;

    assign in_ready  = r_ff.cnt != (AW+1)'(DEPTH);
    assign out_valid = r_ff.cnt != '0;
    assign out_data  = r_ff.mem[r_ff.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_r = r_ff;
        if (push) begin
            nxt_r.mem[r_ff.wr] = in_data;
            nxt_r.wr = (r_ff.wr == AW'(DEPTH - 1)) ? '0 : r_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_r.rd = (r_ff.rd == AW'(DEPTH - 1)) ? '0 : r_ff.rd + 1'b1;
        end
        nxt_r.cnt = r_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule

// [rtl/cmh_core.sv]
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "cmh_regs.svh"
module cmh_core #(
    parameter int NUM_OBJ = 8,
    parameter int Q_DEPTH = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  dbg_rst_n,
    input  wire logic                  dbg_halt,
    output logic                       suspend_active,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  rx_frame_valid,
    output logic                       rx_frame_ready,
    input  wire cmh_pkg::cmh_id_t      rx_frame_id,
    input  wire logic                  rx_frame_remote,
    input  wire logic [31:0]           rx_frame_data,
    input  wire logic                  list_fault,
    output logic                       rx_ack,
    output logic [NUM_OBJ-1:0]         rx_obj_event,
    output logic                       tx_start,
    output cmh_pkg::cmh_id_t           tx_id,
    output logic                       tx_busy,
    input  wire logic                  tx_ok,
    input  wire logic                  tx_err,
    input  wire logic                  rx_pin,
    input  wire logic                  tx_pin,
    input  wire logic                  sample_point,
    input  wire logic                  sync_edge
);
    import cmh_pkg::*;
    localparam int OW = $clog2(NUM_OBJ);

    typedef struct packed {
        logic                      ans_pend;
        logic [OW-1:0]             ans_obj;
        logic                      aw_ok;
        logic                      w_ok;
        logic [7:0]                awaddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        cmh_resp_t                 bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        cmh_resp_t                 rresp;
        logic [31:0]               node_ctrl;
        logic                      list_object_error_flag;
        logic [5:0]                fc_ctrl;
        logic [15:0]               fc_value;
        logic [15:0]               fc_cnt;
        logic                      rx_d;
        logic                      tx_d;
        logic [NUM_OBJ-1:0][31:0]  obj;
        logic                      refilter;
        cmh_tx_e                   tx_state;
        logic [OW-1:0]             tx_obj;
        cmh_id_t                   tx_id;
        logic                      tx_start;
        logic                      rx_ack;
        logic [NUM_OBJ-1:0]        rx_evt;
    } cmh_core_s;

    cmh_core_s    r_ff, nxt_r;
    logic [1:0]   rst_sync_ff;
    logic         rst_core_n;
    logic         susp_cfg_ff;
    logic         q_push, q_in_ready, q_out_valid, q_pop;
    logic [35:0]  q_out;
    logic [35:0]  q_in;

    assign rst_core_n     = rst_sync_ff[1];
    assign s_axi_awready  = !r_ff.aw_ok && !r_ff.bvalid;
    assign s_axi_wready   = !r_ff.w_ok && !r_ff.bvalid;
    assign s_axi_bvalid   = r_ff.bvalid;
    assign s_axi_bresp    = r_ff.bresp;
    assign s_axi_arready  = !r_ff.rvalid;
    assign s_axi_rvalid   = r_ff.rvalid;
    assign s_axi_rdata    = r_ff.rdata;
    assign s_axi_rresp    = r_ff.rresp;
    assign rx_frame_ready = q_in_ready;
    assign rx_ack         = r_ff.rx_ack;
    assign rx_obj_event   = r_ff.rx_evt;
    assign tx_start       = r_ff.tx_start;
    assign tx_id          = r_ff.tx_id;
    assign tx_busy        = r_ff.tx_state == CMH_TX_ACTIVE;
    assign suspend_active = susp_cfg_ff && dbg_halt;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] m;
        m = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic tx_ready(input logic [31:0] o);
        return o[`CMH_O_VALID] && o[`CMH_O_TRANSMIT_REQUEST] && o[`CMH_O_TXA]
               && o[`CMH_O_TXB];
    endfunction

    // Lowest index wins transmit and receive filtering
    logic          tx_found, rx_found;
    logic [OW-1:0] tx_win, rx_win;
    logic [31:0]   tx_cand;
    always_comb begin
        tx_found = 1'b0;
        rx_found = 1'b0;
        tx_win   = '0;
        rx_win   = '0;
        tx_cand  = '0;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            tx_cand = r_ff.obj[i];
            // Invalidated remote answer still gets one run
            if (r_ff.ans_pend && r_ff.ans_obj == OW'(i)) begin
                tx_cand[`CMH_O_VALID] = 1'b1;
            end
            if (tx_ready(tx_cand)) begin
                tx_found = 1'b1;
                tx_win   = OW'(i);
            end
            if (r_ff.obj[i][`CMH_O_VALID] && r_ff.obj[i][`CMH_O_RECEIVE_ALLOW]
                && r_ff.obj[i][`CMH_O_ID_HI:`CMH_O_ID_LO] == rx_frame_id)
            begin
                rx_found = 1'b1;
                rx_win   = OW'(i);
            end
        end
    end

    logic         node_init;
    logic         rx_take;
    logic         wr_go;
    logic [5:0]   widx;
    logic [5:0]   ridx;
    logic [31:0]  old_o;
    logic [31:0]  new_o;
    logic [31:0]  ob;
    logic         fc_on;
    logic         fc_ref;
    logic         fc_hit;
    logic         filt_go;

    assign node_init = r_ff.node_ctrl[`CMH_INIT_BIT];
    assign rx_take   = rx_frame_valid && q_in_ready && !node_init;
    assign q_in      = {4'(rx_win), rx_frame_data};

    always_comb begin
        nxt_r          = r_ff;
        nxt_r.tx_start = 1'b0;
        nxt_r.rx_ack   = 1'b0;
        nxt_r.rx_evt   = '0;
        q_push         = 1'b0;
        q_pop          = 1'b0;
        widx           = r_ff.awaddr[7:2];
        ridx           = s_axi_araddr[7:2];
        old_o          = '0;
        new_o          = '0;
        ob             = '0;
        wr_go          = r_ff.aw_ok && r_ff.w_ok && !r_ff.bvalid;

        // Filter run consumes the trigger; new triggers below win
        filt_go = r_ff.tx_state == CMH_TX_IDLE && r_ff.refilter
                  && !node_init && !list_fault;
        if (filt_go) begin
            nxt_r.refilter = 1'b0;
            nxt_r.ans_pend = 1'b0;
        end

        // Bus write channel
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_r.aw_ok  = 1'b1;
            nxt_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_r.w_ok  = 1'b1;
            nxt_r.wdata = s_axi_wdata;
            nxt_r.wstrb = s_axi_wstrb;
        end
        if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (wr_go) begin
            nxt_r.aw_ok  = 1'b0;
            nxt_r.w_ok   = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp  = `CMH_RESP_OKAY;
            if (widx[5:4] == `CMH_OBJ_BASE && widx[3:0] < 4'(NUM_OBJ))
            begin
                // Each write touches only its own object
                old_o = r_ff.obj[widx[OW-1:0]];
                new_o = merge(old_o, r_ff.wdata, r_ff.wstrb);
                nxt_r.obj[widx[OW-1:0]] = new_o;
                // Any 1 written to request or enables, even if set
                if (r_ff.wstrb[0] && (r_ff.wdata[`CMH_O_TRANSMIT_REQUEST]
                    || r_ff.wdata[`CMH_O_TXA] || r_ff.wdata[`CMH_O_TXB]
                    || r_ff.wdata[`CMH_O_VALID])) begin
                    nxt_r.refilter = 1'b1;
                end
                // Withdrawn request of the selected object
                if (r_ff.tx_obj == widx[OW-1:0] && tx_ready(old_o)
                    && !tx_ready(new_o)) begin
                    nxt_r.refilter = 1'b1;
                end
            end else begin
                case (r_ff.awaddr)
                    `CMH_NODE_CTRL: begin
                        nxt_r.node_ctrl = merge(r_ff.node_ctrl,
                                                r_ff.wdata, r_ff.wstrb);
                    end
                    `CMH_NODE_STAT: begin
                        if (r_ff.wstrb[0] && r_ff.wdata[`CMH_LOE_BIT]) begin
                            nxt_r.list_object_error_flag = 1'b0;
                        end
                    end
                    `CMH_FC_CTRL: begin
                        if (r_ff.wstrb[0]) begin
                            nxt_r.fc_ctrl = r_ff.wdata[5:0];
                        end
                    end
                    `CMH_SUSP_CFG, `CMH_FC_VALUE: begin
                    end
                    default: nxt_r.bresp = `CMH_RESP_SLVERR;
                endcase
            end
        end

        // Bus read channel
        if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r_ff.rvalid) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp  = `CMH_RESP_OKAY;
            nxt_r.rdata  = '0;
            if (ridx[5:4] == `CMH_OBJ_BASE && ridx[3:0] < 4'(NUM_OBJ))
            begin
                nxt_r.rdata = r_ff.obj[ridx[OW-1:0]];
            end else begin
                case (s_axi_araddr)
                    `CMH_NODE_CTRL: nxt_r.rdata = r_ff.node_ctrl;
                    `CMH_NODE_STAT: nxt_r.rdata = 32'(r_ff.list_object_error_flag);
                    `CMH_FC_CTRL:   nxt_r.rdata = 32'(r_ff.fc_ctrl);
                    `CMH_FC_VALUE:  nxt_r.rdata = 32'(r_ff.fc_value);
                    `CMH_SUSP_CFG:  nxt_r.rdata = 32'(susp_cfg_ff);
                    `CMH_RXQ_DATA: begin
                        nxt_r.rdata = q_out[31:0];
                        q_pop       = q_out_valid;
                    end
                    `CMH_RXQ_STAT: begin
                        nxt_r.rdata = {24'h0, q_out[35:32], 3'h0,
                                       q_out_valid};
                    end
                    default: nxt_r.rresp = `CMH_RESP_SLVERR;
                endcase
            end
        end

        // Frame reception; hardware updates come after software write
        if (rx_take) begin
            nxt_r.rx_ack = 1'b1;
            if (list_fault) begin
                nxt_r.list_object_error_flag = 1'b1;
            end else if (rx_found) begin
                ob = nxt_r.obj[rx_win];
                if (rx_frame_remote) begin
                    if (ob[`CMH_O_DIR] && !ob[`CMH_O_FOREIGN_REMOTE_ENABLE]) begin
                        ob[`CMH_O_TRANSMIT_REQUEST] = 1'b1;
                        nxt_r.refilter  = 1'b1;
                        nxt_r.ans_pend  = ob[`CMH_O_SDT];
                        nxt_r.ans_obj   = rx_win;
                    end
                end else begin
                    q_push = 1'b1;
                    ob[`CMH_O_LOST]   = ob[`CMH_O_NEW_DATA_FLAG];
                    ob[`CMH_O_NEW_DATA_FLAG] = 1'b1;
                    ob[`CMH_O_RECEIVE_PENDING_FLAG]  = 1'b1;
                    nxt_r.rx_evt[rx_win] = 1'b1;
                end
                if (ob[`CMH_O_SDT]) begin
                    ob[`CMH_O_VALID] = 1'b0;
                end
                nxt_r.obj[rx_win] = ob;
            end
        end

        // Transmit scheduling
        case (r_ff.tx_state)
            CMH_TX_IDLE: begin
                if (r_ff.refilter && !node_init) begin
                    if (list_fault) begin
                        // Flag stays pending so filtering reruns
                        nxt_r.list_object_error_flag = 1'b1;
                    end else begin
                        if (tx_found) begin
                            // Highest priority goes first
                            nxt_r.tx_obj   = tx_win;
                            nxt_r.tx_id    = r_ff.obj[tx_win]
                                [`CMH_O_ID_HI:`CMH_O_ID_LO];
                            nxt_r.obj[tx_win][`CMH_O_NEW_DATA_FLAG] = 1'b0;
                            nxt_r.tx_start = 1'b1;
                            nxt_r.tx_state = CMH_TX_ACTIVE;
                        end
                    end
                end
            end
            CMH_TX_ACTIVE: begin
                ob = nxt_r.obj[r_ff.tx_obj];
                if (tx_ok) begin
                    ob[`CMH_O_TRANSMIT_REQUEST] = 1'b0;
                    if (ob[`CMH_O_SDT]) begin
                        ob[`CMH_O_VALID] = 1'b0;
                    end
                    nxt_r.obj[r_ff.tx_obj] = ob;
                    nxt_r.refilter = 1'b1;
                    nxt_r.tx_state = CMH_TX_IDLE;
                end else if (tx_err) begin
                    if (tx_ready(ob) && !node_init) begin
                        nxt_r.tx_start = 1'b1;
                    end else begin
                        // Invalid single-transfer answer is dropped
                        nxt_r.refilter = 1'b1;
                        nxt_r.tx_state = CMH_TX_IDLE;
                    end
                end
            end
            default: nxt_r.tx_state = CMH_TX_IDLE;
        endcase

        // Bit timing measurement
        nxt_r.rx_d = rx_pin;
        nxt_r.tx_d = tx_pin;
        fc_on  = r_ff.fc_ctrl[`CMH_FC_FUN_HI:`CMH_FC_FUN_LO]
                 == `CMH_FUN_BITTIME;
        fc_ref = 1'b0;
        fc_hit = 1'b0;
        case (r_ff.fc_ctrl[`CMH_FC_SUB_HI:`CMH_FC_SUB_LO])
            `CMH_SUB_RXREC: begin
                fc_ref = r_ff.rx_d && !rx_pin;
                fc_hit = !r_ff.rx_d && rx_pin;
            end
            `CMH_SUB_TXDOM: begin
                fc_ref = r_ff.tx_d && !tx_pin;
                fc_hit = r_ff.rx_d && !rx_pin;
            end
            `CMH_SUB_TXREC: begin
                fc_ref = !r_ff.tx_d && tx_pin;
                fc_hit = !r_ff.rx_d && rx_pin;
            end
            `CMH_SUB_SYNC: begin
                fc_ref = sample_point;
                fc_hit = sync_edge;
            end
            default: begin
                fc_ref = 1'b0;
                fc_hit = 1'b0;
            end
        endcase
        if (fc_on) begin
            nxt_r.fc_cnt = fc_ref ? 16'h0000 : r_ff.fc_cnt + 16'h0001;
            if (fc_hit) begin
                nxt_r.fc_value = r_ff.fc_cnt + 16'h0001;
            end
        end
    end

    // Debug suspend setting survives application reset
    always_ff @(posedge core_clk or negedge dbg_rst_n) begin
        if (!dbg_rst_n) begin
            susp_cfg_ff <= 1'b0;
        end else if (wr_go && r_ff.awaddr == `CMH_SUSP_CFG
                     && r_ff.wstrb[0]) begin
            susp_cfg_ff <= r_ff.wdata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            r_ff           <= '0;
            r_ff.node_ctrl <= `CMH_NODE_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    cmh_fifo #(
        .WIDTH (36),
        .DEPTH (Q_DEPTH)
    ) u_rxq (
        .core_clk  (core_clk),
        .rst_n     (rst_core_n),
        .in_valid  (q_push),
        .in_ready  (q_in_ready),
        .in_data   (q_in),
        .out_valid (q_out_valid),
        .out_ready (q_pop),
        .out_data  (q_out)
    );
endmodule

// [test/cmh_core_sva.sv]
`timescale 1ns/100ps
module cmh_core_sva #(
    parameter int NUM_OBJ = 8
) (
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               rx_frame_valid,
    input wire logic               rx_frame_ready,
    input wire logic               rx_ack,
    input wire logic [NUM_OBJ-1:0] rx_obj_event,
    input wire logic               tx_start,
    input wire cmh_pkg::cmh_id_t   tx_id,
    input wire logic               tx_busy,
    input wire logic               tx_ok,
    input wire logic               tx_err,
    input wire logic               dbg_halt,
    input wire logic               suspend_active
);
    import cmh_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ack_cause: assert property (rx_ack |-> $past(rx_frame_valid && rx_frame_ready))
        else $error("ack without accepted frame");
    a_event_acked: assert property (|rx_obj_event |-> rx_ack)
        else $error("object event without ack");
    a_event_single: assert property ($onehot0(rx_obj_event))
        else $error("frame stored in several objects");
    a_resend_same: assert property (tx_start && $past(tx_err) |-> tx_id == $past(tx_id))
        else $error("errored frame not resent first");
    a_start_busy: assert property (tx_start |-> tx_busy)
        else $error("start without busy");
    a_busy_start: assert property ($rose(tx_busy) |-> tx_start)
        else $error("busy rose without start");
    a_ok_idle: assert property (tx_ok |=> !tx_busy)
        else $error("busy stays after success");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_susp_halt: assert property (suspend_active |-> dbg_halt)
        else $error("suspend without halt");
    c_ack: cover property (rx_ack && |rx_obj_event);
    c_resend: cover property (tx_start && $past(tx_err));
    c_ok: cover property (tx_ok);
endmodule
bind cmh_core cmh_core_sva #(.NUM_OBJ(NUM_OBJ)) i_cmh_core_sva (.*);

// [test/cmh_bus_node.sv]
`timescale 1ns/100ps
module cmh_bus_node (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic tx_start,
    input  wire logic err_next,
    output logic      tx_ok,
    output logic      tx_err
);
    logic [2:0] cnt_ff;
    logic       arm_ff;
    // Frame lasts a few cycles, then the bus answers good or destroyed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 3'h0;
            arm_ff <= 1'b0;
            tx_ok  <= 1'b0;
            tx_err <= 1'b0;
        end else begin
            tx_ok  <= 1'b0;
            tx_err <= 1'b0;
            if (err_next) arm_ff <= 1'b1;
            if (tx_start) begin
                cnt_ff <= 3'h4;
            end else if (cnt_ff != 3'h0) begin
                cnt_ff <= cnt_ff - 3'h1;
                if (cnt_ff == 3'h1) begin
                    tx_ok  <= !arm_ff;
                    tx_err <= arm_ff;
                    arm_ff <= 1'b0;
                end
            end
        end
    end
endmodule

// [test/tb_can_message_object_handler.sv]
`timescale 1ns/100ps
module tb_can_message_object_handler;
    import cmh_pkg::*;
    logic        core_clk, rst_n, dbg_rst_n, dbg_halt, suspend_active;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_obj_event, ev;
    logic [31:0] s_axi_wdata, s_axi_rdata, rx_frame_data, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, brsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, rx_frame_valid, rx_frame_ready;
    logic        rx_frame_remote, list_fault, rx_ack, tx_start, tx_busy;
    logic        tx_ok, tx_err, err_next, rx_pin, tx_pin, sample_point;
    logic        sync_edge, ak;
    cmh_id_t     rx_frame_id, tx_id;
    cmh_id_t     ids[$];
    int          err_total, check_count;

    cmh_core i_cmh_core (.*);
    cmh_bus_node i_cmh_bus_node (.*);

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) if (tx_start === 1'b1) ids.push_back(tx_id);

    task give_verdict;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw, b;
        @(posedge core_clk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; pa = 1; pw = 1;
        while (pa || pw) begin
            @(negedge core_clk);
            ta = pa && s_axi_awready; tw = pw && s_axi_wready;
            @(posedge core_clk);
            if (ta) begin s_axi_awvalid <= 0; pa = 0; end
            if (tw) begin s_axi_wvalid <= 0; pw = 0; end
        end
        do begin
            @(negedge core_clk);
            b = s_axi_bvalid;
            brsp = s_axi_bresp;
            @(posedge core_clk);
        end while (!b);
        s_axi_bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        logic t;
        @(posedge core_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(negedge core_clk); t = s_axi_arready; @(posedge core_clk); end
        while (!t);
        s_axi_arvalid <= 0;
        do begin
            @(negedge core_clk);
            t = s_axi_rvalid; rdat = s_axi_rdata; rrsp = s_axi_rresp;
            @(posedge core_clk);
        end while (!t);
        s_axi_rready <= 0;
    endtask
    task sendf(input cmh_id_t id, input logic rem);
        logic t;
        @(posedge core_clk);
        rx_frame_id <= id; rx_frame_remote <= rem;
        rx_frame_data <= {21'h0, id}; rx_frame_valid <= 1;
        do begin @(negedge core_clk); t = rx_frame_ready; @(posedge core_clk); end
        while (!t);
        rx_frame_valid <= 0;
        @(negedge core_clk);
        ak = rx_ack; ev = rx_obj_event;
    endtask
    task pulse_err;
        @(posedge core_clk) err_next <= 1;
        @(posedge core_clk) err_next <= 0;
    endtask

    initial begin
        #300us;
        err_total++;
        give_verdict;
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, rx_frame_valid, rx_frame_remote, list_fault} = 0;
        {dbg_halt, err_next, sample_point, sync_edge} = 0;
        {rx_pin, tx_pin} = 2'h3; s_axi_wstrb = 4'hf;
        s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
        rx_frame_id = 0; rx_frame_data = 0;
        rst_n = 0; dbg_rst_n = 0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1; dbg_rst_n <= 1;
        repeat (3) @(posedge core_clk);
        rd(8'h00); chk(rdat, 32'h1);
        rd(8'h3c); chk({30'h0, rrsp}, 32'h2); chk(rdat, 32'h0);
        wr(8'h3c, 32'h1);
        chk({30'h0, brsp}, 32'h2);
        wr(8'h40, 32'h0123_0103);
        chk({30'h0, brsp}, 32'h0);
        wr(8'h00, 32'h0);
        sendf(11'h123, 0); chk({23'h0, ak, ev}, 32'h101);
        rd(8'h40); chk(rdat, 32'h0123_01a2);
        wr(8'h44, 32'h0123_0003);
        @(posedge core_clk) list_fault <= 1;
        sendf(11'h123, 0); chk({23'h0, ak, ev}, 32'h100);
        @(posedge core_clk) list_fault <= 0;
        rd(8'h04); chk({31'h0, rdat[0]}, 32'h1);
        rd(8'h44); chk(rdat, 32'h0123_0003);
        wr(8'h50, 32'h0444_050f);
        pulse_err;
        ids.delete();
        sendf(11'h444, 1);
        repeat (60) @(posedge core_clk);
        chk(32'(ids.size()), 32'h1);
        chk({21'h0, ids[0]}, 32'h444);
        wr(8'h00, 32'h1);
        wr(8'h48, 32'h0200_043d);
        wr(8'h4c, 32'h0300_043d);
        pulse_err;
        ids.delete();
        wr(8'h00, 32'h0);
        repeat (100) @(posedge core_clk);
        chk(32'(ids.size()), 32'h3);
        foreach (ids[i]) chk({21'h0, ids[i]}, i < 2 ? 32'h200 : 32'h300);
        rd(8'h48); chk(rdat, 32'h0200_040d);
        wr(8'h08, 32'h21);
        @(posedge core_clk) rx_pin <= 0;
        repeat (7) @(posedge core_clk);
        rx_pin <= 1;
        rd(8'h0c);
        chk(rdat, 32'h7);
        wr(8'h10, 32'h1);
        @(posedge core_clk) dbg_halt <= 1;
        @(negedge core_clk) chk({31'h0, suspend_active}, 32'h1);
        @(posedge core_clk) rst_n <= 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1;
        @(negedge core_clk) chk({31'h0, suspend_active}, 32'h1);
        @(posedge core_clk) dbg_rst_n <= 0;
        @(posedge core_clk) dbg_rst_n <= 1;
        @(negedge core_clk) chk({31'h0, suspend_active}, 32'h0);
        give_verdict;
    end
endmodule
